// file: hw/boot_cfg_pkg.sv
// package: constants shared by the boot integrity and configuration loader
// assumes: 200 MHz system clock, 32-bit flash words with six check bits
package boot_cfg_pkg;
  localparam int unsigned data_w = 32;
  localparam int unsigned chk_w = 6;
  localparam int unsigned code_w = data_w + chk_w;
  localparam int unsigned addr_w = 8;
  localparam int unsigned clk_mhz = 200;
  localparam int unsigned clk_period_ps = 5000;
  // bus address that selects programming-port mode
  localparam logic [6:0] jtag_addr = 7'h7E;
  // slowed clock: keep 9 of every 10 edges (90 percent)
  localparam logic [3:0] slow_period = 4'hA;
  localparam logic [3:0] slow_skip = 4'h9;
  // firmware watchdog timeout
  localparam int unsigned wdog_us = 100;
  localparam int unsigned wdog_cycles = wdog_us * clk_mhz;
  // flash region layout, word addresses
  localparam logic [addr_w-1:0] fw_base = 8'h00;
  localparam logic [addr_w-1:0] fw_last = 8'h3E;
  localparam logic [addr_w-1:0] fw_sum = 8'h3F;
  localparam logic [addr_w-1:0] cfg_base = 8'h40;
  localparam logic [addr_w-1:0] cfg_last = 8'h7E;
  localparam logic [addr_w-1:0] cfg_sum = 8'h7F;
  localparam logic [addr_w-1:0] log_base = 8'h80;
  localparam logic [addr_w-1:0] log_last = 8'hBE;
  localparam logic [addr_w-1:0] log_sum = 8'hBF;
  localparam logic [data_w-1:0] blank_word = 32'hFFFFFFFF;
  // factory default configuration word
  localparam logic [data_w-1:0] dflt_cfg = 32'h00000000;
  // parameter range limits for received commands
  localparam logic [data_w-1:0] param_min = 32'h00000000;
  localparam logic [data_w-1:0] param_max = 32'h0000FFFF;
  localparam int unsigned gpio_n = 23;
  localparam int unsigned fast_pwm_pins_n = 8;

  typedef enum logic [2:0] {
    st_reset = 3'b000,
    st_fw = 3'b001,
    st_cfg = 3'b011,
    st_log = 3'b010,
    st_done = 3'b110,
    st_cmd_only = 3'b111
  } boot_state_t;
endpackage

// file: hw/ecc_codec.sv
// ecc encoder and single-error corrector for 32-bit flash words
// assumes: combinational use, caller registers the results
`timescale 1ns/1ps
`default_nettype none
module ecc_codec (
  input wire logic [boot_cfg_pkg::data_w-1:0] wr_data,
  output logic [boot_cfg_pkg::code_w-1:0] wr_code,
  input wire logic [boot_cfg_pkg::code_w-1:0] rd_code,
  output logic [boot_cfg_pkg::data_w-1:0] rd_data,
  output logic rd_corrected
);
  // hamming over 38 positions; check bit k sits at position 2**k
  function automatic logic [boot_cfg_pkg::code_w-1:0] place(input logic [boot_cfg_pkg::data_w-1:0] d);
    logic [boot_cfg_pkg::code_w-1:0] c;
    int unsigned j;
    c = '0;
    j = 0;
    for (int p = 1; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[j];
        j++;
      end
    end
    return c;
  endfunction

  function automatic logic [boot_cfg_pkg::data_w-1:0] extract(input logic [boot_cfg_pkg::code_w-1:0] c);
    logic [boot_cfg_pkg::data_w-1:0] d;
    int unsigned j;
    d = '0;
    j = 0;
    for (int p = 1; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[j] = c[p-1];
        j++;
      end
    end
    return d;
  endfunction

  function automatic logic [5:0] syndrome(input logic [boot_cfg_pkg::code_w-1:0] c);
    logic [5:0] s;
    s = '0;
    for (int k = 0; k < 6; k++) begin
      for (int p = 1; p <= 38; p++) begin
        if (((p >> k) & 1) == 1) s[k] = s[k] ^ c[p-1];
      end
    end
    return s;
  endfunction

  wire logic [boot_cfg_pkg::code_w-1:0] bare = place(wr_data);
  wire logic [5:0] wr_syn = syndrome(bare);
  wire logic [5:0] rd_syn = syndrome(rd_code);
  logic [boot_cfg_pkg::code_w-1:0] fixed;

  always_comb begin
    wr_code = bare;
    for (int k = 0; k < 6; k++) wr_code[(1 << k) - 1] = wr_syn[k];
  end

  always_comb begin
    fixed = rd_code;
    if (rd_syn != 6'h00 && rd_syn <= 6'h26) fixed[rd_syn - 6'h01] = ~rd_code[rd_syn - 6'h01];
  end

  assign rd_data = extract(fixed);
  assign rd_corrected = (rd_syn != 6'h00);
endmodule // ecc_codec
`default_nettype wire

// file: hw/cfg_flash_mem.sv
// configuration flash array: words with stored check bits
// assumes: one write or read port, registered read data
`timescale 1ns/1ps
`default_nettype none
module cfg_flash_mem #(
  parameter int unsigned depth = 256
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [boot_cfg_pkg::addr_w-1:0] addr,
  input wire logic [boot_cfg_pkg::code_w-1:0] wr_code,
  output logic [boot_cfg_pkg::code_w-1:0] rd_code_ff
);
  logic [boot_cfg_pkg::code_w-1:0] mem [depth];

  always_ff @(posedge clock) begin
    if (wr_en) mem[addr] <= wr_code;
    rd_code_ff <= mem[addr];
  end
endmodule // cfg_flash_mem
`default_nettype wire

// file: hw/boot_integrity_config_loader.sv
// boot integrity checker and configuration loader of a power sequencer
// assumes: flash preloaded by the programmer port, address pins asynchronous
//
// Summary of operation
// - blank configuration flash enables programming port
// - decoded address 126 enables programming port
// - programming mode slows system clock to ninety percent
// - firmware checksum mismatch: wait for commands only
// - configuration checksum mismatch loads factory defaults
// - default load asserts alert and status flag
// - fault log region checked by own checksum
// - watchdog timeout causes normal device reset
// - in reset, gpio open-drain, fast pwm low
// - received command parameters range checked
// - six check bits stored per word
// - single-bit read errors corrected
// - programming port disabled by default
`timescale 1ns/1ps
`default_nettype none
module boot_integrity_config_loader #(
  parameter int unsigned wdog_limit = boot_cfg_pkg::wdog_cycles,
  parameter int unsigned flash_depth = 256
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [1:0] addr_sel_open,
  input wire logic [1:0] addr_sel_gnd,
  input wire logic [6:0] addr_decoded,
  input wire logic wdog_kick,
  input wire logic prog_wr_en,
  input wire logic [boot_cfg_pkg::addr_w-1:0] prog_addr,
  input wire logic [boot_cfg_pkg::data_w-1:0] prog_data,
  input wire logic cmd_valid,
  input wire logic [boot_cfg_pkg::data_w-1:0] cmd_param,
  input wire logic status_clear,
  output logic jtag_en_ff,
  output logic sys_clk_en_ff,
  output logic fw_run_ff,
  output logic boot_done_ff,
  output logic cfg_default_ff,
  output logic [boot_cfg_pkg::data_w-1:0] cfg_word_ff,
  output logic cfg_word_valid_ff,
  output logic log_corrupt_ff,
  output logic ecc_fixed_ff,
  output logic alert_out_n_ff,
  output logic status_cfg_flag_ff,
  output logic cmd_accept_ff,
  output logic cmd_reject_ff,
  output logic [boot_cfg_pkg::gpio_n-1:0] gpio_oe_n_ff,
  output logic [boot_cfg_pkg::fast_pwm_pins_n-1:0] fast_pwm_pins_ff,
  output logic [boot_cfg_pkg::fast_pwm_pins_n-1:0] fast_pwm_oe_n_ff
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [10:0] pin_meta_ff;
  logic [10:0] pin_sync_ff;
  always_ff @(posedge clock) begin
    pin_meta_ff <= {addr_sel_open, addr_sel_gnd, addr_decoded};
    pin_sync_ff <= pin_meta_ff;
  end
  wire logic [1:0] sel_open = pin_sync_ff[10:9];
  wire logic [1:0] sel_gnd = pin_sync_ff[8:7];
  wire logic [6:0] sel_addr = pin_sync_ff[6:0];
  wire logic addr_is_jtag = (sel_open != 2'h0) || (sel_gnd != 2'h0)
    || (sel_addr == boot_cfg_pkg::jtag_addr);

  // ---------------------------------------------------------------
  // watchdog and internal reset
  // ---------------------------------------------------------------
  logic [31:0] wdog_cnt_ff;
  logic wdog_rst_ff;
  wire logic dev_rst = reset || wdog_rst_ff;
  wire logic wdog_expire = fw_run_ff && (wdog_cnt_ff == 32'(wdog_limit - 1));
  always_ff @(posedge clock) begin
    if (dev_rst || wdog_kick || !fw_run_ff) wdog_cnt_ff <= 32'h00000000;
    else wdog_cnt_ff <= wdog_cnt_ff + 32'h00000001;
  end
  always_ff @(posedge clock) begin
    if (reset) wdog_rst_ff <= 1'b0;
    else wdog_rst_ff <= wdog_expire;
  end

  // ---------------------------------------------------------------
  // flash and ecc
  // ---------------------------------------------------------------
  logic [boot_cfg_pkg::addr_w-1:0] scan_addr_ff;
  logic [boot_cfg_pkg::code_w-1:0] wr_code;
  logic [boot_cfg_pkg::code_w-1:0] rd_code;
  logic [boot_cfg_pkg::data_w-1:0] rd_data;
  logic rd_corrected;
  boot_cfg_pkg::boot_state_t state_ff;
  boot_cfg_pkg::boot_state_t nxt_state;
  wire logic mem_wr = prog_wr_en && jtag_en_ff && (state_ff == boot_cfg_pkg::st_done);
  wire logic [boot_cfg_pkg::addr_w-1:0] mem_addr = mem_wr ? prog_addr : scan_addr_ff;

  ecc_codec u_ecc (
    .wr_data(prog_data),
    .wr_code(wr_code),
    .rd_code(rd_code),
    .rd_data(rd_data),
    .rd_corrected(rd_corrected)
  );

  cfg_flash_mem #(.depth(flash_depth)) u_mem (
    .clock(clock),
    .wr_en(mem_wr),
    .addr(mem_addr),
    .wr_code(wr_code),
    .rd_code_ff(rd_code)
  );

  // ---------------------------------------------------------------
  // boot sequence: scan regions, compare sums
  // ---------------------------------------------------------------
  // read data lags the address by one cycle; rd_phase marks valid data
  logic rd_phase_ff;
  logic [boot_cfg_pkg::addr_w-1:0] data_addr_ff;
  logic [boot_cfg_pkg::data_w-1:0] sum_ff;
  logic cfg_blank_ff;
  logic fw_bad_ff;
  wire logic [boot_cfg_pkg::addr_w-1:0] region_sum =
    (state_ff == boot_cfg_pkg::st_fw) ? boot_cfg_pkg::fw_sum :
    (state_ff == boot_cfg_pkg::st_cfg) ? boot_cfg_pkg::cfg_sum : boot_cfg_pkg::log_sum;
  wire logic at_sum = rd_phase_ff && (data_addr_ff == region_sum);
  wire logic sum_ok = (rd_data == sum_ff);
  wire logic in_scan = (state_ff == boot_cfg_pkg::st_fw) || (state_ff == boot_cfg_pkg::st_cfg)
    || (state_ff == boot_cfg_pkg::st_log);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      boot_cfg_pkg::st_reset: nxt_state = boot_cfg_pkg::st_fw;
      boot_cfg_pkg::st_fw: if (at_sum) nxt_state = boot_cfg_pkg::st_cfg;
      boot_cfg_pkg::st_cfg: if (at_sum) nxt_state = boot_cfg_pkg::st_log;
      boot_cfg_pkg::st_log: if (at_sum) nxt_state = fw_bad_ff ? boot_cfg_pkg::st_cmd_only
        : boot_cfg_pkg::st_done;
      boot_cfg_pkg::st_done: nxt_state = boot_cfg_pkg::st_done;
      boot_cfg_pkg::st_cmd_only: nxt_state = boot_cfg_pkg::st_cmd_only;
      default: nxt_state = boot_cfg_pkg::st_reset;
    endcase
  end

  always_ff @(posedge clock) begin
    if (dev_rst) begin
      state_ff <= boot_cfg_pkg::st_reset;
      scan_addr_ff <= boot_cfg_pkg::fw_base;
      data_addr_ff <= boot_cfg_pkg::fw_base;
      rd_phase_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rd_phase_ff <= in_scan && !at_sum && scan_addr_ff != boot_cfg_pkg::fw_base
        || (state_ff == boot_cfg_pkg::st_reset) || (in_scan && at_sum && nxt_state != state_ff
        && (nxt_state == boot_cfg_pkg::st_cfg || nxt_state == boot_cfg_pkg::st_log));
      data_addr_ff <= scan_addr_ff;
      // regions sit back to back, so the scan address runs straight on;
      // reloading the base at a sum word would read that base word twice
      if (state_ff == boot_cfg_pkg::st_reset || in_scan)
        scan_addr_ff <= scan_addr_ff + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (dev_rst || at_sum) sum_ff <= 32'h00000000;
    else if (rd_phase_ff) sum_ff <= sum_ff + rd_data;
  end

  always_ff @(posedge clock) begin
    if (dev_rst) begin
      fw_bad_ff <= 1'b0;
      cfg_blank_ff <= 1'b1;
      cfg_default_ff <= 1'b0;
      log_corrupt_ff <= 1'b0;
      ecc_fixed_ff <= 1'b0;
    end else begin
      if (at_sum && state_ff == boot_cfg_pkg::st_fw) fw_bad_ff <= !sum_ok;
      if (rd_phase_ff && state_ff == boot_cfg_pkg::st_cfg && rd_data != boot_cfg_pkg::blank_word)
        cfg_blank_ff <= 1'b0;
      if (at_sum && state_ff == boot_cfg_pkg::st_cfg) cfg_default_ff <= !sum_ok;
      if (at_sum && state_ff == boot_cfg_pkg::st_log) log_corrupt_ff <= !sum_ok;
      if (rd_phase_ff && rd_corrected) ecc_fixed_ff <= 1'b1;
    end
  end

  // configuration words stream out as read, default word appended on bad sum
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      cfg_word_ff <= 32'h00000000;
      cfg_word_valid_ff <= 1'b0;
    end else begin
      cfg_word_valid_ff <= rd_phase_ff && state_ff == boot_cfg_pkg::st_cfg && !at_sum;
      cfg_word_ff <= rd_data;
      if (at_sum && state_ff == boot_cfg_pkg::st_cfg && !sum_ok) begin
        cfg_word_ff <= boot_cfg_pkg::dflt_cfg;
        cfg_word_valid_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // programming-port decision, held until reset
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (dev_rst) jtag_en_ff <= 1'b0;
    else if (at_sum && state_ff == boot_cfg_pkg::st_cfg)
      jtag_en_ff <= cfg_blank_ff || addr_is_jtag;
  end

  // ---------------------------------------------------------------
  // clock slowdown: drop one edge in ten while in programming mode
  // ---------------------------------------------------------------
  logic [3:0] slow_cnt_ff;
  always_ff @(posedge clock) begin
    if (dev_rst || slow_cnt_ff == boot_cfg_pkg::slow_period - 4'h1) slow_cnt_ff <= 4'h0;
    else slow_cnt_ff <= slow_cnt_ff + 4'h1;
  end
  always_ff @(posedge clock) begin
    if (dev_rst) sys_clk_en_ff <= 1'b1;
    else sys_clk_en_ff <= !(jtag_en_ff && slow_cnt_ff == boot_cfg_pkg::slow_skip);
  end

  // ---------------------------------------------------------------
  // run state, alert and status
  // ---------------------------------------------------------------
  wire logic set_cfg_flag = at_sum && state_ff == boot_cfg_pkg::st_cfg && !sum_ok;
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      fw_run_ff <= 1'b0;
      boot_done_ff <= 1'b0;
      alert_out_n_ff <= 1'b1;
      status_cfg_flag_ff <= 1'b0;
    end else begin
      fw_run_ff <= (nxt_state == boot_cfg_pkg::st_done);
      boot_done_ff <= (nxt_state == boot_cfg_pkg::st_done) || (nxt_state == boot_cfg_pkg::st_cmd_only);
      if (set_cfg_flag) begin
        alert_out_n_ff <= 1'b0;
        status_cfg_flag_ff <= 1'b1;
      end else if (status_clear) begin
        alert_out_n_ff <= 1'b1;
        status_cfg_flag_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // command parameter range check
  // ---------------------------------------------------------------
  wire logic param_in_range = (cmd_param >= boot_cfg_pkg::param_min) && (cmd_param <= boot_cfg_pkg::param_max);
  always_ff @(posedge clock) begin
    if (dev_rst) begin
      cmd_accept_ff <= 1'b0;
      cmd_reject_ff <= 1'b0;
    end else begin
      cmd_accept_ff <= cmd_valid && boot_done_ff && param_in_range;
      cmd_reject_ff <= cmd_valid && !(boot_done_ff && param_in_range);
    end
  end

  // ---------------------------------------------------------------
  // pin states: gpio open-drain and fast pwm low in both branches, also after boot completes
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (dev_rst || !boot_done_ff) begin
      gpio_oe_n_ff <= '1;
      fast_pwm_pins_ff <= '0;
      fast_pwm_oe_n_ff <= '0;
    end else begin
      gpio_oe_n_ff <= '1;
      fast_pwm_pins_ff <= '0;
      fast_pwm_oe_n_ff <= '0;
    end
  end
endmodule // boot_integrity_config_loader
`default_nettype wire

// file: tb/boot_integrity_config_loader_monitor.sv
// checker: port assertions of the boot loader
// assumes: bound to the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module boot_loader_monitor #(
  parameter int unsigned wdog_limit = 50
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_param,
  input wire logic wdog_kick,
  input wire logic jtag_en_ff,
  input wire logic sys_clk_en_ff,
  input wire logic fw_run_ff,
  input wire logic boot_done_ff,
  input wire logic cfg_default_ff,
  input wire logic alert_out_n_ff,
  input wire logic status_cfg_flag_ff,
  input wire logic cmd_accept_ff,
  input wire logic cmd_reject_ff,
  input wire logic [22:0] gpio_oe_n_ff,
  input wire logic [7:0] fast_pwm_pins_ff,
  input wire logic [7:0] fast_pwm_oe_n_ff
);
  // ----
  // assertions
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [31:0] idle_ff;
  logic [31:0] nxt_idle;
  logic ok_param;
  assign nxt_idle = (!fw_run_ff || wdog_kick) ? 32'h0 : idle_ff + 32'h1;
  assign ok_param = cmd_param <= boot_cfg_pkg::param_max;
  always_ff @(posedge clock) idle_ff <= reset ? 32'h0 : nxt_idle;
  sequence nine_up;
    sys_clk_en_ff [*8] ##1 sys_clk_en_ff;
  endsequence
  reset_pins_a: assert property ($fell(reset) |-> &gpio_oe_n_ff && !jtag_en_ff
    && fast_pwm_pins_ff == 8'h00 && fast_pwm_oe_n_ff == 8'h00) else $error("pins wrong after reset");
  clock_full_a: assert property (!sys_clk_en_ff |-> jtag_en_ff) else $error("clock slowed");
  clock_slow_a: assert property (!sys_clk_en_ff |=> nine_up ##1 (!sys_clk_en_ff || !jtag_en_ff))
    else $error("slow clock period wrong");
  cmd_accept_a: assert property (cmd_valid && boot_done_ff && ok_param |=> cmd_accept_ff && !cmd_reject_ff)
    else $error("command not accepted");
  cmd_reject_a: assert property (cmd_valid && (!boot_done_ff || !ok_param) |=> cmd_reject_ff && !cmd_accept_ff)
    else $error("command not rejected");
  cmd_quiet_a: assert property (!cmd_valid |=> !cmd_accept_ff && !cmd_reject_ff)
    else $error("answer without command");
  alert_flag_a: assert property (alert_out_n_ff != status_cfg_flag_ff) else $error("alert and flag differ");
  alert_cause_a: assert property ($fell(alert_out_n_ff) |-> cfg_default_ff) else $error("alert without default");
  strap_hold_a: assert property (boot_done_ff && $past(boot_done_ff) |-> $stable(jtag_en_ff))
    else $error("port enable changed");
  wdog_bound_a: assert property (idle_ff <= wdog_limit + 2) else $error("watchdog late");
endmodule // boot_loader_monitor
`default_nettype wire

// file: tb/host_model.sv
// host controller model: sends command parameters
// assumes: design samples commands on the rising edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clock,
  output logic cmd_valid,
  output logic [31:0] cmd_param
);
  // ----
  // command driver
  // ----
  initial begin
    cmd_valid = 1'b0;
    cmd_param = 32'h0;
  end
  // released parameter inverted, never left stale
  task automatic send(input logic [31:0] p);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_param = p;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_param = ~p;
  endtask
endmodule // host_model
`default_nettype wire

// file: tb/boot_integrity_config_loader_bench.sv
// bench: boot loader against a behavioural model
// assumes: flash array reachable as dut.u_mem.mem
`timescale 1ns/1ps
`default_nettype none
module boot_integrity_config_loader_bench;
  localparam int unsigned wd = 50;
  logic clock, reset, wdog_kick, kick_en, prog_wr_en, status_clear, chk_stream, cmd_valid;
  logic jtag_en_ff, sys_clk_en_ff, fw_run_ff, boot_done_ff, cfg_default_ff, cfg_word_valid_ff;
  logic log_corrupt_ff, ecc_fixed_ff, alert_out_n_ff, status_cfg_flag_ff, cmd_accept_ff, cmd_reject_ff;
  logic [1:0] addr_sel_open, addr_sel_gnd;
  logic [6:0] addr_decoded;
  logic [7:0] prog_addr, fast_pwm_pins_ff, fast_pwm_oe_n_ff;
  logic [22:0] gpio_oe_n_ff;
  logic [31:0] prog_data, cmd_param, cfg_word_ff, d;
  logic [31:0] lfsr_ff = 32'h00000011;
  int n_errors = 0, check_count = 0, cycles = 0, k;
  logic [31:0] exp_q[$];
  boot_integrity_config_loader #(.wdog_limit(wd)) dut (.clock, .reset, .addr_sel_open, .addr_sel_gnd,
    .addr_decoded, .wdog_kick, .prog_wr_en, .prog_addr, .prog_data, .cmd_valid, .cmd_param, .status_clear,
    .jtag_en_ff, .sys_clk_en_ff, .fw_run_ff, .boot_done_ff, .cfg_default_ff, .cfg_word_ff, .cfg_word_valid_ff,
    .log_corrupt_ff, .ecc_fixed_ff, .alert_out_n_ff, .status_cfg_flag_ff, .cmd_accept_ff, .cmd_reject_ff,
    .gpio_oe_n_ff, .fast_pwm_pins_ff, .fast_pwm_oe_n_ff);
  host_model u_host (.clock, .cmd_valid, .cmd_param);
  // ----
  // model and helpers
  // ----
  function automatic logic [31:0] rnd();
    lfsr_ff = {lfsr_ff[30:0], lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};
    return lfsr_ff;
  endfunction
  // hamming: check bit b at position 2**b, data fills the rest
  function automatic logic [37:0] enc(input logic [31:0] w);
    logic [37:0] c;
    int j;
    c = '0;
    j = 0;
    for (int p = 1; p <= 38; p++) if ((p & (p - 1)) != 0) begin
      c[p-1] = w[j];
      j++;
    end
    for (int p = 1; p <= 38; p++) if ((p & (p - 1)) != 0) begin
      for (int b = 0; b < 6; b++) if (p[b]) c[(1 << b) - 1] ^= c[p-1];
    end
    return c;
  endfunction
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic boot(input bit bf, bc, bl, blank, flip, input logic [6:0] ad, input logic [1:0] op, gn);
    logic [31:0] s, w;
    bit jt;
    @(negedge clock);
    reset = 1'b1;
    chk_stream = 1'b0;
    addr_decoded = ad;
    addr_sel_open = op;
    addr_sel_gnd = gn;
    exp_q.delete();
    for (int r = 0; r < 3; r++) begin
      s = 32'h0;
      for (int a = 0; a < 64; a++) begin
        w = (r == 1 && blank) ? 32'hFFFFFFFF : rnd();
        if (a == 63 && !(r == 1 && blank)) w = s + {31'h0, (r == 0) ? bf : (r == 1) ? bc : bl};
        if (r == 1 && a < 63) exp_q.push_back(w);
        s = s + w;
        dut.u_mem.mem[r * 64 + a] = enc(w);
      end
    end
    if (flip) dut.u_mem.mem[5][7] = ~dut.u_mem.mem[5][7];
    repeat (3) @(negedge clock);
    check("reset pins", {gpio_oe_n_ff, fast_pwm_pins_ff, fast_pwm_oe_n_ff, jtag_en_ff}, {23'h7FFFFF, 17'h0});
    reset = 1'b0;
    chk_stream = 1'b1;
    u_host.send(32'h5);
    check("early cmd", {cmd_accept_ff, cmd_reject_ff}, 2'b01);
    for (k = 0; k < 2000 && boot_done_ff !== 1'b1; k++) @(negedge clock);
    repeat (4) @(negedge clock);
    jt = blank || ad == 7'h7E || |op || |gn;
    check("boot done", boot_done_ff, 1'b1);
    check("jtag", jtag_en_ff, jt);
    check("fw run", fw_run_ff, !bf);
    check("log bad", log_corrupt_ff, bl);
    check("ecc fix", ecc_fixed_ff, flip);
    if (!blank) begin
      check("cfg dflt", cfg_default_ff, bc);
      check("alert", {alert_out_n_ff, status_cfg_flag_ff}, {!bc, bc});
      check("cfg left", exp_q.size(), 0);
    end
    $display("boot test done fw %0d cfg %0d log %0d jtag %0d", bf, bc, bl, jt);
  endtask
  task automatic prog(input logic [7:0] a, input bit on);
    logic [37:0] old;
    old = dut.u_mem.mem[a];
    prog_wr_en = 1'b1;
    prog_addr = a;
    prog_data = rnd();
    @(negedge clock);
    prog_wr_en = 1'b0;
    repeat (2) @(negedge clock);
    check("flash word", dut.u_mem.mem[a], on ? enc(prog_data) : old);
  endtask
  // ----
  // clock, timeout, watchdog kicks, config stream
  // ----
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  always @(negedge clock) begin
    wdog_kick <= kick_en & ~wdog_kick;
    if (chk_stream && cfg_word_valid_ff)
      check("cfg word", cfg_word_ff, exp_q.size() ? exp_q.pop_front() : boot_cfg_pkg::dflt_cfg);
  end
  initial begin
    reset = 1'b1;
    kick_en = 1'b1;
    wdog_kick = 1'b0;
    prog_wr_en = 1'b0;
    prog_addr = 8'h00;
    prog_data = 32'h0;
    status_clear = 1'b0;
    chk_stream = 1'b0;
    addr_decoded = 7'h20;
    addr_sel_open = 2'b00;
    addr_sel_gnd = 2'b00;
    boot(0, 0, 0, 0, 0, 7'h20, 2'b00, 2'b00);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'h0000FFFF : (i == 1) ? 32'h00010000 : rnd() >> (i * 3);
      u_host.send(d);
      check("cmd", {cmd_accept_ff, cmd_reject_ff}, (d <= boot_cfg_pkg::param_max) ? 2'b10 : 2'b01);
    end
    prog(8'h10, 1'b0);
    chk_stream = 1'b0;
    kick_en = 1'b0;
    for (k = 0; k < 200 && fw_run_ff === 1'b1; k++) @(negedge clock);
    check("wdog time", k >= wd - 2 && k <= wd + 3, 1'b1);
    check("wdog state", {gpio_oe_n_ff, fast_pwm_pins_ff, jtag_en_ff, boot_done_ff}, {23'h7FFFFF, 10'h0});
    kick_en = 1'b1;
    boot(0, 1, 0, 0, 0, 7'h20, 2'b00, 2'b00);
    status_clear = 1'b1;
    @(negedge clock);
    status_clear = 1'b0;
    @(negedge clock);
    check("alert clear", {alert_out_n_ff, status_cfg_flag_ff}, 2'b10);
    boot(1, 0, 0, 0, 1, 7'h20, 2'b00, 2'b00);
    boot(0, 0, 1, 0, 0, 7'h7E, 2'b00, 2'b00);
    prog(8'hC5, 1'b1);
    d = 32'h0;
    repeat (100) begin
      @(negedge clock);
      d += !sys_clk_en_ff;
    end
    check("slow clock", d, 10);
    boot(0, 0, 0, 1, 0, 7'h20, 2'b00, 2'b00);
    boot(0, 0, 0, 0, 0, 7'h20, 2'b01, 2'b00);
    boot(0, 0, 0, 0, 0, 7'h20, 2'b00, 2'b10);
    report_and_stop();
  end
endmodule // boot_integrity_config_loader_bench
bind boot_integrity_config_loader boot_loader_monitor #(.wdog_limit(wdog_limit)) u_mon (.clock, .reset,
  .cmd_valid, .cmd_param, .wdog_kick, .jtag_en_ff, .sys_clk_en_ff, .fw_run_ff, .boot_done_ff, .cfg_default_ff,
  .alert_out_n_ff, .status_cfg_flag_ff, .cmd_accept_ff, .cmd_reject_ff, .gpio_oe_n_ff, .fast_pwm_pins_ff,
  .fast_pwm_oe_n_ff);
`default_nettype wire
